// [design/pdtg_regs.vh]
/*
 * Register offsets, field positions, reset values and encodings of the
 * deadtime and trigger generator.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef PDTG_REGS_VH
`define PDTG_REGS_VH

// Byte offsets on the Avalon-MM register port.
`define PDTG_ADDR_W 8
`define PDTG_OFF_DEADTIME 8'h68
`define PDTG_OFF_TRIGCTL 8'h6c
`define PDTG_OFF_CTRL 8'h70
`define PDTG_OFF_IRQSTAT 8'h74
`define PDTG_OFF_IRQMASK 8'h78

// Deadtime control fields.
`define PDTG_DT_VAL_LSB 0
`define PDTG_DT_VAL_MSB 5
`define PDTG_DT_PS_LSB 6
`define PDTG_DT_PS_MSB 7
`define PDTG_DT_RESET 8'h00

// Prescale select codes.
`define PDTG_PS_DIV4 2'h2
`define PDTG_PS_DIV16 2'h3

// Prescale counter limits: the division factor minus one.
`define PDTG_PS_LIM1 4'h0
`define PDTG_PS_LIM4 4'h3
`define PDTG_PS_LIM16 4'hf

// Trigger control fields.
`define PDTG_TRG_FLAG_BIT 7
`define PDTG_TRG_INIT_BIT 6
`define PDTG_TRG_EN_MSB 5
`define PDTG_TRG_RESET 8'h00

// Local control register: write protect disable and pair enables.
`define PDTG_CTRL_WRITE_PROTECT_DISABLE_BIT 0
`define PDTG_CTRL_DTEN_LSB 1
`define PDTG_CTRL_DTEN_MSB 4
`define PDTG_CTRL_COMP_LSB 5
`define PDTG_CTRL_COMP_MSB 8
`define PDTG_CTRL_RESET 9'h000

// Interrupt status bits.
`define PDTG_IRQ_CHTRIG 0
`define PDTG_IRQ_INITTRIG 1
`define PDTG_IRQ_RESET 2'h0

// Counter widths and channel counts.
`define PDTG_CNT_W 16
`define PDTG_NCH 8
`define PDTG_NPAIR 4
`define PDTG_TRG_NCH 6
`define PDTG_DTC_W 10

`endif

// [design/pdtg_dt_pair.v]
/*
 * Deadtime insertion for one complementary channel pair.
 * Assumes a shared prescale tick from the parent and a deadtime
 * length already expressed in prescaled counts.
 */
`include "pdtg_regs.vh"

module pdtg_dt_pair (
    // Clock and reset.
    input wire clk,
    input wire nrst,
    // Shared deadtime timing.
    input wire psTick,
    input wire [`PDTG_DT_VAL_MSB:0] dtCount,
    // Pair configuration.
    input wire dtEnable,
    input wire compEnable,
    // Raw channel outputs from the compare logic.
    input wire chA,
    input wire chB,
    // Outputs after deadtime insertion.
    output reg outA_q,
    output reg outB_q
);

    reg [`PDTG_DT_VAL_MSB:0] waitA_q;
    reg [`PDTG_DT_VAL_MSB:0] waitB_q;
    wire wantB;
    wire insert;

    // In complementary mode the second output is derived from the first.
    assign wantB = compEnable ? ~chA : chB;
    assign insert = dtEnable && compEnable && (dtCount != 6'h00);

    // Rising edges wait dtCount prescaled ticks and leave on a tick; falling
    // edges pass at once. The shared prescaler runs free, so leaving on a tick
    // keeps the span at least factor times count when the first period is partial.
    always @(posedge clk) begin
        if (!nrst) begin
            waitA_q <= 6'h00;
            waitB_q <= 6'h00;
            outA_q <= 1'b0;
            outB_q <= 1'b0;
        end else begin
            if (!insert) begin
                outA_q <= chA;
                outB_q <= wantB;
                waitA_q <= 6'h00;
                waitB_q <= 6'h00;
            end else begin
                if (!chA) begin
                    outA_q <= 1'b0;
                    waitA_q <= dtCount;
                end else if (waitA_q == 6'h00) begin
                    if (psTick) begin
                        outA_q <= 1'b1;
                    end
                end else if (psTick) begin
                    waitA_q <= waitA_q - 6'h01;
                end
                if (!wantB) begin
                    outB_q <= 1'b0;
                    waitB_q <= dtCount;
                end else if (waitB_q == 6'h00) begin
                    if (psTick) begin
                        outB_q <= 1'b1;
                    end
                end else if (psTick) begin
                    waitB_q <= waitB_q - 6'h01;
                end
            end
        end
    end

endmodule // pdtg_dt_pair

// [design/pdtg_top.v]
/*
 * Deadtime insertion and external trigger generation for a PWM timer,
 * with an Avalon-MM register slave and a level interrupt.
 * Assumes the main counter, counter initial value and channel match values
 * come from the surrounding timer, all synchronous to clk.
 */
// The Avalon-MM register port was chosen for this implementation.
`include "pdtg_regs.vh"

// Operation
// - One prescale setting and one count serve every channel pair.
// - Prescale code 0x divides by 1, 10 by 4, 11 by 16.
// - The deadtime counter advances on the prescaled tick only.
// - Count value zero inserts nothing; each step adds one count, up to 63.
// - Deadtime in clocks equals division factor times count value; the free-running prescaler adds up to factor minus one clocks.
// - Deadtime fields accept writes only while write protect disable is one.
// - Deadtime register bits 31 to 8 read zero and ignore writes.
// - With init trigger enabled, counter equal to initial value fires a trigger.
// - Each enabled channel match fires its own trigger within a period; here all matches share chTrigger_q, so coincident matches give one pulse.
// - Channels six and seven never produce channel triggers.
// - Trigger flag sets whenever a channel trigger is produced.
// - Flag clears by read while set then write zero; new trigger restarts.
// - Each channel trigger enable fires on counter equal to its match value.
module pdtg_top (
    // Clock and reset.
    input wire clk,
    input wire nrst,
    // Avalon-MM register slave.
    input wire [`PDTG_ADDR_W-1:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWritedata,
    input wire [3:0] avsByteenable,
    output reg [31:0] avsReaddata_q,
    output reg avsWaitrequest_q,
    // Timer counter and match values.
    input wire [`PDTG_CNT_W-1:0] counterValue,
    input wire [`PDTG_CNT_W-1:0] counterInitialValue,
    input wire [`PDTG_CNT_W*`PDTG_NCH-1:0] channelMatchValue,
    // Raw channel outputs before deadtime.
    input wire [`PDTG_NCH-1:0] chRaw,
    // Outputs to the gate drivers.
    output wire [`PDTG_NCH-1:0] pwmOut,
    // Trigger outputs.
    output reg extTrigger_q,
    output reg initTrigger_q,
    output reg chTrigger_q,
    // Interrupt.
    output reg irq_q
);

    // Register map, one 32-bit word per offset:
    //   0x68 deadtime control, prescale select in bits 7:6, count in bits 5:0.
    //   0x6c trigger control, flag in bit 7, init enable in bit 6, enables in 5:0.
    //   0x70 local control, write protect disable and the pair enables.
    //   0x74 interrupt status, write one to clear.
    //   0x78 interrupt mask, same layout as the status.
    // Only byte lane 0 carries fields, apart from bit 8 of the local control.
    // Offsets are compared in full, so sub-word addresses read as unmapped.

    // Register state.
    reg [1:0] dtPrescale_q;
    reg [5:0] dtValue_q;
    reg [`PDTG_TRG_EN_MSB:0] trigEnable_q;
    reg initTrigEnable_q;
    reg trigFlag_q;
    reg flagArmed_q;
    reg [`PDTG_CTRL_COMP_MSB:0] ctrl_q;
    reg [1:0] irqStat_q;
    reg [1:0] irqMask_q;
    reg [3:0] psCount_q;
    reg psTick_q;
    reg [`PDTG_CNT_W-1:0] lastCounter_q;
    reg counterSeen_q;

    // Decode and helper nets.
    reg [31:0] rdData;
    reg [`PDTG_TRG_NCH-1:0] matchHit;
    reg [3:0] psLimit;
    wire access;
    wire wrDeadtime;
    wire wrTrig;
    wire wrCtrl;
    wire wrStat;
    wire wrMask;
    wire rdTrig;
    wire counterMoved;
    wire initHit;
    wire chHit;
    wire [31:0] dtReg;
    wire [31:0] trigReg;
    wire wrTrigLane;
    wire [1:0] irqSet;
    wire [1:0] irqClear;
    integer i;

    // One wait cycle per access keeps read data registered. A request counts
    // only while waitrequest stands high, so the answer edge, at which the
    // master still holds its request, is never taken as a second access.
    // Writes act at the taking edge.
    assign access = (avsRead || avsWrite) && avsWaitrequest_q;
    assign wrDeadtime = access && avsWrite && (avsAddress == `PDTG_OFF_DEADTIME);
    assign wrTrig = access && avsWrite && (avsAddress == `PDTG_OFF_TRIGCTL);
    assign wrCtrl = access && avsWrite && (avsAddress == `PDTG_OFF_CTRL);
    assign wrStat = access && avsWrite && (avsAddress == `PDTG_OFF_IRQSTAT);
    assign wrMask = access && avsWrite && (avsAddress == `PDTG_OFF_IRQMASK);
    assign rdTrig = access && avsRead && (avsAddress == `PDTG_OFF_TRIGCTL);
    assign wrTrigLane = wrTrig && avsByteenable[0];

    // Upper bits are hard zero, so they can never be written.
    assign dtReg = {24'h000000, dtPrescale_q, dtValue_q};
    assign trigReg = {24'h000000, trigFlag_q, initTrigEnable_q, trigEnable_q};

    // Triggers fire once per counter value, so a stalled counter does not repeat.
    // Without this, a timer halted on a match value would fire on every clock
    // and flood the trigger consumers.
    assign counterMoved = !counterSeen_q || (counterValue != lastCounter_q);
    assign initHit = initTrigEnable_q && counterMoved &&
                     (counterValue == counterInitialValue);
    assign chHit = |matchHit;

    // Only channels 0 to 5 are compared; 6 and 7 are not wired in at all.
    always @* begin
        matchHit = 6'h00;
        for (i = 0; i < `PDTG_TRG_NCH; i = i + 1) begin
            matchHit[i] = trigEnable_q[i] && counterMoved &&
                (counterValue == channelMatchValue[i*`PDTG_CNT_W +: `PDTG_CNT_W]);
        end
    end

    // Trigger enable bit i selects channel i directly, which keeps the compare
    // loop free of a remap; software written for another bit order must remap.
    // Prescale limit: codes 0x give a tick every clock.
    always @* begin
        if (dtPrescale_q == `PDTG_PS_DIV16) begin
            psLimit = `PDTG_PS_LIM16;
        end else if (dtPrescale_q == `PDTG_PS_DIV4) begin
            psLimit = `PDTG_PS_LIM4;
        end else begin
            psLimit = `PDTG_PS_LIM1;
        end
    end

    // Shared prescaler, giving at least factor times count clocks of deadtime.
    // It runs free rather than restarting per edge, because one prescaler
    // serves every pair; the pair units absorb the partial first period.
    always @(posedge clk) begin
        if (!nrst) begin
            psCount_q <= 4'h0;
            psTick_q <= 1'b0;
        end else if (psCount_q >= psLimit) begin
            psCount_q <= 4'h0;
            psTick_q <= 1'b1;
        end else begin
            psCount_q <= psCount_q + 4'h1;
            psTick_q <= 1'b0;
        end
    end

    // Deadtime and control registers. Write protection guards only the
    // deadtime fields; the local control register stays writable, which is
    // what lets software lift the protection in the first place.
    always @(posedge clk) begin
        if (!nrst) begin
            dtPrescale_q <= 2'h0;
            dtValue_q <= 6'h00;
            ctrl_q <= `PDTG_CTRL_RESET;
            irqMask_q <= `PDTG_IRQ_RESET;
        end else begin
            if (wrDeadtime && avsByteenable[0] && ctrl_q[`PDTG_CTRL_WRITE_PROTECT_DISABLE_BIT]) begin
                dtPrescale_q <= avsWritedata[`PDTG_DT_PS_MSB:`PDTG_DT_PS_LSB];
                dtValue_q <= avsWritedata[`PDTG_DT_VAL_MSB:`PDTG_DT_VAL_LSB];
            end
            if (wrCtrl && avsByteenable[0]) begin
                ctrl_q[7:0] <= avsWritedata[7:0];
            end
            if (wrCtrl && avsByteenable[1]) begin
                ctrl_q[8] <= avsWritedata[8];
            end
            if (wrMask && avsByteenable[0]) begin
                irqMask_q <= avsWritedata[1:0];
            end
        end
    end

    // Trigger enables and the init enable, written through byte lane 0.
    always @(posedge clk) begin
        if (!nrst) begin
            trigEnable_q <= 6'h00;
            initTrigEnable_q <= 1'b0;
        end else if (wrTrigLane) begin
            trigEnable_q <= avsWritedata[`PDTG_TRG_EN_MSB:0];
            initTrigEnable_q <= avsWritedata[`PDTG_TRG_INIT_BIT];
        end
    end

    // The flag clear is a two-step sequence. A read that sees the flag set
    // arms it, and a later write of zero to the flag bit clears it. A channel
    // trigger in between disarms, so software that raced a new trigger still
    // finds the flag set. Writing one to the flag bit never clears it.
    always @(posedge clk) begin
        if (!nrst) begin
            trigFlag_q <= 1'b0;
            flagArmed_q <= 1'b0;
        end else if (chHit) begin
            trigFlag_q <= 1'b1;
            flagArmed_q <= 1'b0;
        end else if (rdTrig && trigFlag_q) begin
            flagArmed_q <= 1'b1;
        end else if (wrTrigLane && flagArmed_q && !avsWritedata[`PDTG_TRG_FLAG_BIT]) begin
            trigFlag_q <= 1'b0;
            flagArmed_q <= 1'b0;
        end
    end

    // Trigger pulses, one clock per event. The combined output serves
    // consumers that want any trigger; pulses and status see the same hit,
    // so the two never disagree.
    always @(posedge clk) begin
        if (!nrst) begin
            lastCounter_q <= 16'h0000;
            counterSeen_q <= 1'b0;
            extTrigger_q <= 1'b0;
            initTrigger_q <= 1'b0;
            chTrigger_q <= 1'b0;
        end else begin
            lastCounter_q <= counterValue;
            counterSeen_q <= 1'b1;
            initTrigger_q <= initHit;
            chTrigger_q <= chHit;
            extTrigger_q <= initHit || chHit;
        end
    end

    // Clear and set masks of the status bits: bit 0 channel, bit 1 init.
    assign irqClear = (wrStat && avsByteenable[0]) ? avsWritedata[1:0] : 2'h0;
    assign irqSet = {initHit, chHit};

    // Sticky interrupt status; a set in the same cycle beats the clear.
    always @(posedge clk) begin
        if (!nrst) begin
            irqStat_q <= `PDTG_IRQ_RESET;
            irq_q <= 1'b0;
        end else begin
            irqStat_q <= (irqStat_q & ~irqClear) | irqSet;
            irq_q <= |(irqStat_q & irqMask_q);
        end
    end

    // Read mux; unmapped offsets read zero. It decodes the live address, and
    // the wait cycle registers its result, so read data never glitch.
    always @* begin
        if (avsAddress == `PDTG_OFF_DEADTIME) begin
            rdData = dtReg;
        end else if (avsAddress == `PDTG_OFF_TRIGCTL) begin
            rdData = trigReg;
        end else if (avsAddress == `PDTG_OFF_CTRL) begin
            rdData = {23'h000000, ctrl_q};
        end else if (avsAddress == `PDTG_OFF_IRQSTAT) begin
            rdData = {30'h00000000, irqStat_q};
        end else if (avsAddress == `PDTG_OFF_IRQMASK) begin
            rdData = {30'h00000000, irqMask_q};
        end else begin
            rdData = 32'h00000000;
        end
    end

    // Bus handshake: waitrequest drops for exactly one cycle per access.
    // It idles high, reset included, so no answer is seen during reset, and
    // back-to-back accesses take two cycles each. Write answers carry zero
    // so that a stale read word is never mistaken for fresh data.
    always @(posedge clk) begin
        if (!nrst) begin
            avsWaitrequest_q <= 1'b1;
            avsReaddata_q <= 32'h00000000;
        end else if (access) begin
            avsWaitrequest_q <= 1'b0;
            avsReaddata_q <= avsRead ? rdData : 32'h00000000;
        end else begin
            avsWaitrequest_q <= 1'b1;
        end
    end

    // One deadtime unit per pair, all fed the same timing. Pair p drives
    // outputs 2p and 2p+1, and takes its deadtime and complement enables
    // from bits 1+p and 5+p of the local control register.
    genvar p;
    generate
        for (p = 0; p < `PDTG_NPAIR; p = p + 1) begin : gPair
            pdtg_dt_pair uPair (
                .clk(clk),
                .nrst(nrst),
                .psTick(psTick_q),
                .dtCount(dtValue_q),
                .dtEnable(ctrl_q[`PDTG_CTRL_DTEN_LSB + p]),
                .compEnable(ctrl_q[`PDTG_CTRL_COMP_LSB + p]),
                .chA(chRaw[2*p]),
                .chB(chRaw[2*p+1]),
                .outA_q(pwmOut[2*p]),
                .outB_q(pwmOut[2*p+1])
            );
        end
    endgenerate

endmodule // pdtg_top

// [tb/pdtg_checker.sv]
/*
 * Port assertions for the deadtime and trigger generator.
 * Assumes a bind from the bench and a master that holds each request.
 */
`include "pdtg_regs.vh"

module pdtg_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register port.
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsReaddata_q,
    input wire logic avsWaitrequest_q,
    // Timer values and triggers.
    input wire logic [15:0] counterValue,
    input wire logic [15:0] counterInitialValue,
    input wire logic [127:0] channelMatchValue,
    input wire logic extTrigger_q,
    input wire logic initTrigger_q,
    input wire logic chTrigger_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic initHit_q;
    logic chHit_q;
    logic mapped;

    // Last cycle's matches, so that each pulse is tied to its cause.
    always @(posedge clk) begin
        initHit_q <= counterValue == counterInitialValue;
        chHit_q <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            if (channelMatchValue[16*i +: 16] == counterValue) chHit_q <= 1'b1;
        end
    end

    // Only the five word addresses of the block answer with data.
    assign mapped = avsAddress >= 8'h68 && avsAddress <= 8'h78 && avsAddress[1:0] == 2'b00;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_take; (avsRead || avsWrite) && avsWaitrequest_q |=> !avsWaitrequest_q; endproperty
    a_take: assert property (p_take) else $error("request not answered next cycle");
    property p_one; !avsWaitrequest_q |=> avsWaitrequest_q; endproperty
    a_one: assert property (p_one) else $error("answer stood longer than one cycle");
    property p_idle; !avsRead && !avsWrite && avsWaitrequest_q |=> avsWaitrequest_q; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_rsvd;
        !avsWaitrequest_q && avsRead && avsAddress == `PDTG_OFF_DEADTIME
            |-> avsReaddata_q[31:8] == 24'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved deadtime bits set");
    property p_unmap; !avsWaitrequest_q && avsRead && !mapped |-> avsReaddata_q == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_wrz; !avsWaitrequest_q && avsWrite |-> avsReaddata_q == 32'h0; endproperty
    a_wrz: assert property (p_wrz) else $error("write answer carries data");
    property p_init; initTrigger_q |-> initHit_q; endproperty
    a_init: assert property (p_init) else $error("init trigger without match");
    property p_ch; chTrigger_q |-> chHit_q; endproperty
    a_ch: assert property (p_ch) else $error("channel trigger without match");
    property p_ext; initTrigger_q || chTrigger_q |-> extTrigger_q; endproperty
    a_ext: assert property (p_ext) else $error("trigger missing on output");
endmodule // pdtg_checker

// [tb/pdtg_stage_model.sv]
/*
 * Stand-in for the gate drivers and trigger consumers.
 * Assumes one clock; the bench reads the trigger tallies as differences and the overlap tally whole.
 */
module pdtg_stage_model (
    // Clock.
    input wire logic clk,
    // Pair outputs and triggers.
    input wire logic [7:0] pwmOut,
    input wire logic initTrigger_q,
    input wire logic chTrigger_q,
    // Tallies for the bench.
    output int initCnt,
    output int chCnt,
    output int overlapCnt
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both switches of a pair on at once would short the rail. The tallies
    // are two-state, so they start at zero without an initial block.
    always @(posedge clk) begin
        initCnt <= initCnt + initTrigger_q;
        chCnt <= chCnt + chTrigger_q;
        overlapCnt <= overlapCnt + (pwmOut[0] & pwmOut[1]) + (pwmOut[2] & pwmOut[3]);
    end
endmodule // pdtg_stage_model

// [tb/tb_pdtg_top.sv]
/*
 * Self-checking bench for the deadtime and trigger generator.
 * Assumes the design files and the stage model are compiled first.
 */
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, s); end end

module tb_pdtg_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] avsAddress = 8'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [3:0] avsByteenable = 4'hf;
    logic [15:0] counterValue = 16'hffff;
    logic [15:0] counterInitialValue = 16'h0000;
    logic [127:0] channelMatchValue = 128'h0;
    logic [7:0] chRaw = 8'h00;
    wire [31:0] avsReaddata_q;
    wire avsWaitrequest_q;
    wire [7:0] pwmOut;
    wire extTrigger_q;
    wire initTrigger_q;
    wire chTrigger_q;
    wire irq_q;
    int error_cnt = 0;
    int samples_checked = 0;
    int initCnt;
    int chCnt;
    int overlapCnt;

    // A 40 MHz clock.
    always #12.5 clk = ~clk;

    pdtg_top i_pdtg_top (.clk(clk), .nrst(nrst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
        .avsReaddata_q(avsReaddata_q), .avsWaitrequest_q(avsWaitrequest_q),
        .counterValue(counterValue), .counterInitialValue(counterInitialValue),
        .channelMatchValue(channelMatchValue), .chRaw(chRaw), .pwmOut(pwmOut),
        .extTrigger_q(extTrigger_q), .initTrigger_q(initTrigger_q),
        .chTrigger_q(chTrigger_q), .irq_q(irq_q));

    pdtg_stage_model i_pdtg_stage_model (.clk(clk), .pwmOut(pwmOut),
        .initTrigger_q(initTrigger_q), .chTrigger_q(chTrigger_q),
        .initCnt(initCnt), .chCnt(chCnt), .overlapCnt(overlapCnt));

    // Prints the verdict and ends the run.
    task automatic wrap_up;
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One access; the request is held until waitrequest is seen low.
    task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= !w;
        avsWritedata <= d;
        do @(posedge clk); while (avsWaitrequest_q !== 1'b0);
        q = avsReaddata_q;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        av(1'b0, a, 32'h0, q);
        `CHK(n, e, q)
    endtask

    // Reset values, write protection, byte lanes and reserved bits.
    task automatic t_regs;
        rd_chk("deadtime reset", 8'h68, 32'h0);
        rd_chk("trigger reset", 8'h6c, 32'h0);
        wr(8'h68, 32'h000000c5);
        rd_chk("protected write", 8'h68, 32'h0);
        wr(8'h70, 32'h1);
        wr(8'h68, 32'hffffffff);
        rd_chk("reserved bits", 8'h68, 32'hff);
        avsByteenable <= 4'he;
        wr(8'h68, 32'h0);
        avsByteenable <= 4'hf;
        rd_chk("lane zero off", 8'h68, 32'hff);
        wr(8'h40, 32'hffffffff);
        rd_chk("unmapped", 8'h40, 32'h0);
    endtask

    // Rising edge of pairs 0 and 1 is delayed by factor times count; pair 2
    // passes straight through and pair 3 is complementary without deadtime.
    task automatic t_dead(input logic [1:0] ps, input logic [5:0] v);
        int f;
        int n;
        f = ps[1] ? (ps[0] ? 16 : 4) : 1;
        wr(8'h70, 32'h167);
        wr(8'h68, {24'h0, ps, v});
        chRaw <= 8'h00;
        repeat (80) @(posedge clk);
        chRaw <= 8'h35;
        n = 0;
        while (pwmOut[0] !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        `CHK("pair levels", 8'hb5, pwmOut)
        `CHK("deadtime span", 1'b1, n >= f * v && n <= f * v + f + 3)
    endtask

    // Counter walks 0 to 23 once; init matches at 3, channels 0 to 5 at 10 to 15.
    task automatic sweep;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            counterValue <= 16'(i);
        end
        repeat (3) @(posedge clk);
    endtask

    // Triggers, the flag clear sequence and the interrupt.
    task automatic t_trig;
        int c0;
        int i0;
        for (int i = 0; i < 8; i++) channelMatchValue[16*i +: 16] <= 16'(10 + i);
        counterInitialValue <= 16'h0003;
        wr(8'h6c, 32'h7f);
        c0 = chCnt;
        i0 = initCnt;
        sweep();
        `CHK("channel triggers", 6, chCnt - c0)
        `CHK("init triggers", 1, initCnt - i0)
        wr(8'h6c, 32'h7f);
        rd_chk("flag kept", 8'h6c, 32'hff);
        wr(8'h6c, 32'h7f);
        rd_chk("flag cleared", 8'h6c, 32'h7f);
        sweep();
        rd_chk("flag set again", 8'h6c, 32'hff);
        sweep();
        wr(8'h6c, 32'h7f);
        rd_chk("flag restarted", 8'h6c, 32'hff);
        rd_chk("irq status", 8'h74, 32'h3);
        `CHK("irq masked", 1'b0, irq_q)
        wr(8'h78, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq raised", 1'b1, irq_q)
        wr(8'h74, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq_q)
        rd_chk("status after clear", 8'h74, 32'h2);
    endtask

    // A hang counts as a mismatch and ends the run the usual way.
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_dead(2'b00, 6'd5);
        t_dead(2'b01, 6'd7);
        t_dead(2'b10, 6'd3);
        t_dead(2'b11, 6'd2);
        t_dead(2'b11, 6'd0);
        t_dead(2'b00, 6'd63);
        t_trig();
        `CHK("pair overlap", 0, overlapCnt)
        wrap_up();
    end
endmodule // tb_pdtg_top

bind pdtg_top pdtg_checker i_pdtg_checker (.clk(clk), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsReaddata_q(avsReaddata_q),
    .avsWaitrequest_q(avsWaitrequest_q), .counterValue(counterValue),
    .counterInitialValue(counterInitialValue), .channelMatchValue(channelMatchValue),
    .extTrigger_q(extTrigger_q), .initTrigger_q(initTrigger_q), .chTrigger_q(chTrigger_q));
